//--- inc/dbg_tap_pkg.sv
// constants, instruction codes and tap state type of the debug test port
package dbg_tap_pkg;

    // ==========================================================================
    // clocking
    // ==========================================================================
    localparam int          CLK_PERIOD_NS   = 40;

    // ==========================================================================
    // instruction register
    // ==========================================================================
    localparam int          IR_LEN          = 4;
    localparam logic [3:0]  INS_EXTEST      = 4'h0;
    localparam logic [3:0]  INS_IDCODE      = 4'h2;
    localparam logic [3:0]  INS_CLAMP       = 4'h3;
    localparam logic [3:0]  INS_SAMPLE      = 4'h4;
    localparam logic [3:0]  INS_HIGHZ       = 4'h5;
    localparam logic [3:0]  INS_RST_ASSERT  = 4'h6;
    localparam logic [3:0]  INS_RST_NEGATE  = 4'h7;
    localparam logic [3:0]  INS_DBG_IRQ     = 4'h8;
    localparam logic [3:0]  INS_BYPASS      = 4'hF;
    localparam logic [3:0]  IR_CAPTURE      = 4'h1;
    localparam logic [3:0]  IR_RESET        = INS_IDCODE;

    // ==========================================================================
    // identity register
    // ==========================================================================
    // value is arbitrary; bit 0 stays one as the scan standard wants
    localparam logic [27:0] ID_LOW28        = 28'h0A53C01;
    localparam int          ID_LEN          = 32;
    localparam int          ID_HALF         = 16;
    localparam logic [3:0]  DBG_IRQ_LEVEL   = 4'hF;

    // ==========================================================================
    // boundary chain: control cells nearest the scan output
    // ==========================================================================
    localparam int          NPIN            = 8;
    localparam int          BSR_LEN         = 24;
    localparam int          BSR_CTRL_LSB    = 0;
    localparam int          BSR_OUT_LSB     = 8;
    localparam int          BSR_IN_LSB      = 16;

    // ==========================================================================
    // synchroniser bit positions and reset values
    // ==========================================================================
    localparam int          SY_TCK          = 0;
    localparam int          SY_TMS          = 1;
    localparam int          SY_TDI          = 2;
    localparam int          SY_TRST         = 3;
    localparam int          SY_RES          = 4;
    localparam int          SY_EMU          = 5;
    localparam logic [5:0]  CTL_SYNC_INIT   = 6'h38;
    localparam logic [7:0]  PAD_SYNC_INIT   = 8'h00;

    typedef enum logic [3:0] {
        TAP_EX2_DR  = 4'h0, TAP_EX1_DR  = 4'h1, TAP_SHIFT_DR = 4'h2, TAP_PAUSE_DR = 4'h3,
        TAP_SEL_IR  = 4'h4, TAP_UPD_DR  = 4'h5, TAP_CAP_DR   = 4'h6, TAP_SEL_DR   = 4'h7,
        TAP_EX2_IR  = 4'h8, TAP_EX1_IR  = 4'h9, TAP_SHIFT_IR = 4'hA, TAP_PAUSE_IR = 4'hB,
        TAP_IDLE    = 4'hC, TAP_UPD_IR  = 4'hD, TAP_CAP_IR   = 4'hE, TAP_RESET    = 4'hF
    } tap_state_t;

endpackage

//--- hdl/pin_sync.sv
// two flip-flop synchroniser for a group of pins
`timescale 1ns/100ps
module pin_sync #(
    parameter int           W    = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input  wire logic         clk_in,
    input  wire logic         rst_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    // ==========================================================================
    // stages
    // ==========================================================================
    // first stage is read by the second stage only
    logic [W-1:0] meta_q;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            meta_q <= INIT;
            q_out  <= INIT;
        end else begin
            meta_q <= d_in;
            q_out  <= meta_q;
        end
    end
endmodule

//--- hdl/tap_fsm.sv
// tap controller state sequencer
`timescale 1ns/100ps
module tap_fsm (
    input  wire logic                  clk_in,
    input  wire logic                  rst_in,
    input  wire logic                  trst_n_in,
    input  wire logic                  step_in,
    input  wire logic                  tms_in,
    output dbg_tap_pkg::tap_state_t    state_out,
    output dbg_tap_pkg::tap_state_t    next_out
);
    import dbg_tap_pkg::*;

    tap_state_t state_q;
    tap_state_t state_d;

    // ==========================================================================
    // next state
    // ==========================================================================
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            TAP_RESET:    state_d = tms_in ? TAP_RESET  : TAP_IDLE;
            TAP_IDLE:     state_d = tms_in ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR:   state_d = tms_in ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR:   state_d = tms_in ? TAP_EX1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: state_d = tms_in ? TAP_EX1_DR : TAP_SHIFT_DR;
            TAP_EX1_DR:   state_d = tms_in ? TAP_UPD_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: state_d = tms_in ? TAP_EX2_DR : TAP_PAUSE_DR;
            TAP_EX2_DR:   state_d = tms_in ? TAP_UPD_DR : TAP_SHIFT_DR;
            TAP_UPD_DR:   state_d = tms_in ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR:   state_d = tms_in ? TAP_RESET  : TAP_CAP_IR;
            TAP_CAP_IR:   state_d = tms_in ? TAP_EX1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: state_d = tms_in ? TAP_EX1_IR : TAP_SHIFT_IR;
            TAP_EX1_IR:   state_d = tms_in ? TAP_UPD_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: state_d = tms_in ? TAP_EX2_IR : TAP_PAUSE_IR;
            TAP_EX2_IR:   state_d = tms_in ? TAP_UPD_IR : TAP_SHIFT_IR;
            TAP_UPD_IR:   state_d = tms_in ? TAP_SEL_DR : TAP_IDLE;
        endcase
    end

    // trst wins over a tck step; it acts on the next clk_in edge and does not wait for a tck edge
    always_ff @(posedge clk_in) begin
        if (rst_in || !trst_n_in) begin
            state_q <= TAP_RESET;
        end else if (step_in) begin
            state_q <= state_d;
        end
    end

    assign state_out = state_q;
    assign next_out  = state_d;

    // ==========================================================================
    // checks
    // ==========================================================================
    a_trst_forces_reset: assert property (@(posedge clk_in) disable iff (rst_in)
        !trst_n_in |=> state_q == TAP_RESET) else $error("trst did not force reset state");
    a_state_holds_idle: assert property (@(posedge clk_in) disable iff (rst_in)
        (!step_in && trst_n_in) |=> $stable(state_q)) else $error("state moved without tck edge");
    a_tms_ones_reset: assert property (@(posedge clk_in) disable iff (rst_in)
        (step_in && tms_in && trst_n_in && state_q == TAP_SEL_IR) |=> state_q == TAP_RESET)
        else $error("select-ir with tms high did not reach reset");
endmodule

//--- hdl/dbg_tap_top.sv
// debug test access port with identity, boundary scan and debug commands
// Functional notes
// - 32-bit read-only identity, two readable halves
// - idcode in shift-dr shifts identity out
// - upper four identity bits vary by version
// - tap follows standard graph on tms
// - sample tdi on rise, shift on fall
// - tdo driven only in shift states
// - trst low forces reset state at once
// - normal mode reset combinations of pins
// - emulator mode reset hold until reassert
// - standard instructions change tdo on fall
// - debug commands change tdo on rise
// - reset assert command holds reset until negate
// - debug interrupt command raises level 15 request
// - no commands in standby; tester holds tck (the bench still scans in standby, and ir_load is blocked)
// - bypass selects one-bit register, system untouched
// - sample captures pins in capture-dr
// - preload fills latch; extest drives latch out
// - extest drives outputs, captures inputs
// - reset or trst selects idcode instruction
// - chain excludes clock, reset, mode, tap pins
// - command persists; repeat needs other between
// - control cell low drives pin from output cell
`timescale 1ns/100ps
module dbg_tap_top #(
    parameter logic [3:0] SILICON_VERSION = 4'h0
) (
    input  wire logic                          clk_in,
    input  wire logic                          rst_in,
    input  wire logic                          tck_in,
    input  wire logic                          tms_in,
    input  wire logic                          tdi_in,
    input  wire logic                          trst_n_in,
    input  wire logic                          sys_reset_n_in,
    input  wire logic                          emu_mode_sel_n_in,
    input  wire logic                          standby_in,
    input  wire logic                          irq_ack_in,
    input  wire logic [dbg_tap_pkg::NPIN-1:0]  core_data_in,
    input  wire logic [dbg_tap_pkg::NPIN-1:0]  core_oe_in,
    input  wire logic [dbg_tap_pkg::NPIN-1:0]  pad_data_in,
    output logic                               tdo_out,
    output logic                               tdo_oe_out,
    output logic      [dbg_tap_pkg::NPIN-1:0]  pad_data_out,
    output logic      [dbg_tap_pkg::NPIN-1:0]  pad_oe_out,
    output logic      [dbg_tap_pkg::ID_HALF-1:0] identity_upper_half_out,
    output logic      [dbg_tap_pkg::ID_HALF-1:0] identity_lower_half_out,
    output logic      [dbg_tap_pkg::IR_LEN-1:0]  debug_instruction_out,
    output logic                               chip_reset_out,
    output logic                               debug_port_reset_out,
    output logic                               cpu_hold_out,
    output logic                               debug_irq_out,
    output logic      [3:0]                    debug_irq_level_out
);
    import dbg_tap_pkg::*;

    // ==========================================================================
    // pin synchronisers and tck edges
    // ==========================================================================
    logic [5:0]      ctl_s;
    logic [NPIN-1:0] pad_s;
    logic            tck_prev_q;
    tap_state_t      tap_q;
    tap_state_t      tap_nxt;

    pin_sync #(.W(6), .INIT(CTL_SYNC_INIT)) u_ctl_sync (
        .clk_in (clk_in),
        .rst_in (rst_in),
        .d_in   ({emu_mode_sel_n_in, sys_reset_n_in, trst_n_in, tdi_in, tms_in, tck_in}),
        .q_out  (ctl_s)
    );
    pin_sync #(.W(NPIN), .INIT(PAD_SYNC_INIT)) u_pad_sync (
        .clk_in (clk_in),
        .rst_in (rst_in),
        .d_in   (pad_data_in),
        .q_out  (pad_s)
    );

    wire tck_s    = ctl_s[SY_TCK];
    wire tms_s    = ctl_s[SY_TMS];
    wire tdi_s    = ctl_s[SY_TDI];
    wire trst_s   = ctl_s[SY_TRST];
    wire res_s    = ctl_s[SY_RES];
    wire emu_s    = ctl_s[SY_EMU];
    wire tck_rise = tck_s & ~tck_prev_q;
    wire tck_fall = ~tck_s & tck_prev_q;

    tap_fsm u_fsm (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .trst_n_in (trst_s),
        .step_in   (tck_rise),
        .tms_in    (tms_s),
        .state_out (tap_q),
        .next_out  (tap_nxt)
    );

    // ==========================================================================
    // state
    // ==========================================================================
    logic [IR_LEN-1:0]  ir_sr_q;
    logic [IR_LEN-1:0]  ir_q;
    logic               bypass_q;
    logic [ID_LEN-1:0]  id_sr_q;
    logic [BSR_LEN-1:0] bsr_q;
    logic [BSR_LEN-1:0] bsr_latch_q;
    logic               tdi_smp_q;
    logic               shdr_pend_q;
    logic               shir_pend_q;
    logic               dbg_reset_q;
    logic               hold_q;
    logic               res_prev_q;
    logic               trst_prev_q;

    // ==========================================================================
    // decode
    // ==========================================================================
    wire [ID_LEN-1:0]  id_value   = {SILICON_VERSION, ID_LOW28};
    // only the function pins are cells; clock, reset, mode and tap pins never join
    wire [BSR_LEN-1:0] bsr_cap    = {pad_s, core_data_in, ~core_oe_in};
    wire sel_id      = (ir_q == INS_IDCODE);
    wire sel_bsr     = (ir_q == INS_EXTEST) | (ir_q == INS_SAMPLE);
    wire sel_byp     = ~sel_id & ~sel_bsr;
    wire is_dbg      = (ir_q == INS_RST_ASSERT) | (ir_q == INS_RST_NEGATE) | (ir_q == INS_DBG_IRQ);
    wire drive_latch = (ir_q == INS_EXTEST) | (ir_q == INS_CLAMP);
    wire float_all   = (ir_q == INS_HIGHZ);
    wire in_shift    = (tap_q == TAP_SHIFT_DR) | (tap_q == TAP_SHIFT_IR);
    wire nxt_shift   = (tap_nxt == TAP_SHIFT_DR) | (tap_nxt == TAP_SHIFT_IR);
    wire in_capture  = (tap_q == TAP_CAP_DR) | (tap_q == TAP_CAP_IR);
    wire ir_path     = tck_rise ? (tap_nxt == TAP_SHIFT_IR) : (tap_q == TAP_SHIFT_IR);
    wire shift_bit   = tck_rise ? tdi_s : tdi_smp_q;
    wire dr_now      = sel_id ? id_sr_q[0] : sel_bsr ? bsr_q[0] : bypass_q;
    wire dr_after    = sel_id ? id_sr_q[1] : sel_bsr ? bsr_q[1] : shift_bit;
    wire dr_cap      = sel_id ? id_value[0] : sel_bsr ? bsr_cap[0] : 1'b0;
    wire lsb_now     = ir_path ? ir_sr_q[0] : dr_now;
    wire lsb_after   = ir_path ? ir_sr_q[1] : dr_after;
    wire lsb_cap     = ir_path ? IR_CAPTURE[0] : dr_cap;
    // commands are not taken while the core sits in standby
    wire ir_load     = tck_rise & (tap_q == TAP_UPD_IR) & ~standby_in;
    wire irq_set     = ir_load & (ir_sr_q == INS_DBG_IRQ) & (ir_q != INS_DBG_IRQ);
    wire hold_enter  = ~emu_s & ~res_s & ~trst_s;
    wire hold_leave  = (res_prev_q & ~res_s) | (trst_prev_q & ~trst_s);

    // ==========================================================================
    // tdo timing
    // ==========================================================================
    // debug commands show the next bit half a tck early, on the rising edge
    logic tdo_d;
    always_comb begin
        tdo_d = tdo_out;
        if (is_dbg && tck_rise && nxt_shift) begin
            tdo_d = in_capture ? lsb_cap : in_shift ? lsb_after : lsb_now;
        end else if (!is_dbg && tck_fall && in_shift) begin
            tdo_d = (shdr_pend_q | shir_pend_q) ? lsb_after : lsb_now;
        end
    end

    // ==========================================================================
    // tap side registers
    // ==========================================================================
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            tck_prev_q  <= 1'b0;
            tdi_smp_q   <= 1'b0;
            shdr_pend_q <= 1'b0;
            shir_pend_q <= 1'b0;
        end else begin
            tck_prev_q <= tck_s;
            if (tck_rise) begin
                tdi_smp_q   <= tdi_s;
                shdr_pend_q <= (tap_q == TAP_SHIFT_DR);
                shir_pend_q <= (tap_q == TAP_SHIFT_IR);
            end else if (tck_fall) begin
                shdr_pend_q <= 1'b0;
                shir_pend_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in || !trst_s || tap_q == TAP_RESET) begin
            ir_q    <= IR_RESET;
            ir_sr_q <= IR_CAPTURE;
        end else if (tck_rise && tap_q == TAP_CAP_IR) begin
            ir_sr_q <= IR_CAPTURE;
        end else if (tck_fall && shir_pend_q) begin
            ir_sr_q <= {tdi_smp_q, ir_sr_q[IR_LEN-1:1]};
        end else if (ir_load) begin
            ir_q <= ir_sr_q;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            bypass_q    <= 1'b0;
            id_sr_q     <= '0;
            bsr_q       <= '0;
            bsr_latch_q <= '0;
        end else if (tck_rise && tap_q == TAP_CAP_DR) begin
            bypass_q <= 1'b0;
            if (sel_id) id_sr_q <= id_value;
            if (sel_bsr) bsr_q <= bsr_cap;
        end else if (tck_fall && shdr_pend_q) begin
            if (sel_byp) bypass_q <= tdi_smp_q;
            if (sel_id) id_sr_q <= {tdi_smp_q, id_sr_q[ID_LEN-1:1]};
            if (sel_bsr) bsr_q <= {tdi_smp_q, bsr_q[BSR_LEN-1:1]};
        end else if (tck_rise && tap_q == TAP_UPD_DR && sel_bsr) begin
            bsr_latch_q <= bsr_q;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            tdo_out    <= 1'b0;
            tdo_oe_out <= 1'b0;
        end else begin
            tdo_out    <= tdo_d;
            tdo_oe_out <= in_shift;
        end
    end

    // ==========================================================================
    // pins and system side outputs
    // ==========================================================================
    wire [NPIN-1:0] pad_out_d = drive_latch ? bsr_latch_q[BSR_OUT_LSB +: NPIN] : core_data_in;
    // control cells are active low: zero drives the pin
    wire [NPIN-1:0] pad_oe_d  = float_all ? '0 :
                                drive_latch ? ~bsr_latch_q[BSR_CTRL_LSB +: NPIN] : core_oe_in;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pad_data_out <= '0;
            pad_oe_out   <= '0;
        end else begin
            pad_data_out <= pad_out_d;
            pad_oe_out   <= pad_oe_d;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            dbg_reset_q   <= 1'b0;
            debug_irq_out <= 1'b0;
        end else begin
            if (ir_load && ir_sr_q == INS_RST_ASSERT) begin
                dbg_reset_q <= 1'b1;
            end else if (ir_load && ir_sr_q == INS_RST_NEGATE) begin
                dbg_reset_q <= 1'b0;
            end
            if (irq_set) begin
                debug_irq_out <= 1'b1;
            end else if (irq_ack_in) begin
                debug_irq_out <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            hold_q      <= 1'b0;
            res_prev_q  <= 1'b1;
            trst_prev_q <= 1'b1;
        end else begin
            res_prev_q  <= res_s;
            trst_prev_q <= trst_s;
            if (hold_enter) begin
                hold_q <= 1'b1;
            end else if (hold_leave) begin
                hold_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            chip_reset_out          <= 1'b1;
            debug_port_reset_out    <= 1'b0;
            cpu_hold_out            <= 1'b0;
            identity_upper_half_out <= '0;
            identity_lower_half_out <= '0;
            debug_instruction_out   <= IR_RESET;
            debug_irq_level_out     <= 4'h0;
        end else begin
            chip_reset_out          <= ~res_s | dbg_reset_q;
            debug_port_reset_out    <= ~trst_s;
            cpu_hold_out            <= hold_q;
            identity_upper_half_out <= id_value[ID_LEN-1:ID_HALF];
            identity_lower_half_out <= id_value[ID_HALF-1:0];
            debug_instruction_out   <= ir_q;
            debug_irq_level_out     <= DBG_IRQ_LEVEL;
        end
    end

    // ==========================================================================
    // checks
    // ==========================================================================
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    sequence s_assert_cmd;
        ir_load && ir_sr_q == INS_RST_ASSERT;
    endsequence
    sequence s_negate_cmd;
        ir_load && ir_sr_q == INS_RST_NEGATE;
    endsequence

    a_tdo_idle_float: assert property (!in_shift |=> !tdo_oe_out)
        else $error("tdo driven outside shift states");
    a_std_tdo_fall: assert property (!is_dbg && $past(!is_dbg) && $changed(tdo_out) |-> $past(tck_fall))
        else $error("standard tdo changed off falling edge");
    a_dbg_tdo_rise: assert property (is_dbg && $past(is_dbg) && $changed(tdo_out) |-> $past(tck_rise))
        else $error("debug tdo changed off rising edge");
    a_trst_idcode: assert property (!trst_s |=> ir_q == INS_IDCODE)
        else $error("trst did not select idcode");
    a_reset_cmd_held: assert property (s_assert_cmd ##1 (!(ir_load && ir_sr_q == INS_RST_NEGATE))[*2]
        |-> chip_reset_out) else $error("debug reset not applied");
    a_reset_cmd_free: assert property (s_negate_cmd ##1 res_s |=> !chip_reset_out)
        else $error("debug reset not released");
    a_irq_raised: assert property (irq_set |=> debug_irq_out ##1 (debug_irq_out || $past(irq_ack_in)))
        else $error("debug interrupt not raised");
    a_standby_block: assert property (tck_rise && tap_q == TAP_UPD_IR && standby_in && trst_s |=> $stable(ir_q))
        else $error("command taken in standby");
    a_extest_drive: assert property (ir_q == INS_EXTEST |=> pad_data_out == $past(bsr_latch_q[BSR_OUT_LSB +: NPIN]))
        else $error("extest output not from latch");
    a_highz_float: assert property (ir_q == INS_HIGHZ |=> pad_oe_out == '0)
        else $error("highz left a pin driven");
    a_sys_reset: assert property (!res_s |=> chip_reset_out)
        else $error("system reset not passed on");
    a_hold_stays: assert property (hold_q && !hold_leave |=> hold_q ##1 cpu_hold_out)
        else $error("reset hold dropped early");
    a_id_halves: assert property ($past(!rst_in) |-> {identity_upper_half_out, identity_lower_half_out} == id_value)
        else $error("identity halves wrong");
endmodule

//--- tb/jtag_tester.sv
// tester model driving the debug port link pins
`timescale 1ns/100ps
module jtag_tester (
    output logic      tck_out,
    output logic      tms_out,
    output logic      tdi_out,
    input  wire logic tdo_in,
    input  wire logic tdo_oe_in
);
    // ==========================================
    // link cycles
    // ==========================================
    initial begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tdi_out = 1'b0;
    end
    // tms/tdi move while tck is low so they are steady at the rise
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        tms_out = tms;
        tdi_out = tdi;
        // taken just before the rise: settled under both tdo timings, last bit still driven
        #160 tdo = tdo_oe_in ? tdo_in : 1'bz;
        tck_out = 1'b1;
        #160 tck_out = 1'b0;
    endtask
    // from idle through one scan back to idle, lsb first
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        logic t;
        dout = '0;
        step(1'b1, 1'b0, t);
        if (ir) step(1'b1, 1'b0, t);
        step(1'b0, 1'b0, t);
        step(1'b0, 1'b0, t);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], t);
            dout[i] = t;
        end
        step(1'b1, 1'b0, t);
        step(1'b0, 1'b0, t);
    endtask
endmodule

//--- tb/testbench.sv
// self-checking bench of the debug test port
`timescale 1ns/100ps
module testbench;
    import dbg_tap_pkg::*;
    localparam logic [31:0] ID_EXP = {4'hA, ID_LOW28};
    logic clk_in, rst_in, trst_n, res_n, ack, tck, tms, tdi, tdo, tdo_oe;
    logic emu_n, stby, crst, irq, prst, hold;
    logic [7:0] core_d, core_oe, pad_d, pad_q, pad_oe_q;
    logic [15:0] id_hi, id_lo;
    logic [3:0] instr, lvl;
    logic [31:0] d;
    logic t;
    int mismatches, check_count;
    jtag_tester u_jtag_tester (.tck_out(tck), .tms_out(tms), .tdi_out(tdi), .tdo_in(tdo), .tdo_oe_in(tdo_oe));
    dbg_tap_top #(.SILICON_VERSION(4'hA)) u_dbg_tap_top (.clk_in(clk_in), .rst_in(rst_in),
        .tck_in(tck), .tms_in(tms), .tdi_in(tdi), .trst_n_in(trst_n), .sys_reset_n_in(res_n),
        .emu_mode_sel_n_in(emu_n), .standby_in(stby), .irq_ack_in(ack), .core_data_in(core_d),
        .core_oe_in(core_oe), .pad_data_in(pad_d), .tdo_out(tdo), .tdo_oe_out(tdo_oe),
        .pad_data_out(pad_q), .pad_oe_out(pad_oe_q), .identity_upper_half_out(id_hi),
        .identity_lower_half_out(id_lo), .debug_instruction_out(instr), .chip_reset_out(crst),
        .debug_port_reset_out(prst), .cpu_hold_out(hold), .debug_irq_out(irq), .debug_irq_level_out(lvl));
    // ==========================================
    // checking and closing
    // ==========================================
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic ld(input logic [3:0] c);
        u_jtag_tester.scan(1'b1, 4, {28'h0, c}, d);
        repeat (4) @(negedge clk_in);
    endtask
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    // generous bound: the scans need about 60 us
    initial begin
        #400000;
        mismatches++;
        wrap_up();
    end
    // ==========================================
    // tests
    // ==========================================
    initial begin
        {rst_in, trst_n, res_n, emu_n, ack, stby} = 6'h3C;
        {core_d, core_oe, pad_d} = 24'hA5FF3C;
        repeat (4) @(negedge clk_in);
        rst_in = 1'b0;
        repeat (4) @(negedge clk_in);
        check("id_upper", ID_EXP[31:16], id_hi);
        check("id_lower", ID_EXP[15:0], id_lo);
        check("instr", INS_IDCODE, instr);
        check("tdo_oe", 0, tdo_oe);
        u_jtag_tester.step(1'b0, 1'b0, t);
        u_jtag_tester.scan(1'b0, 32, 32'h0, d);
        check("id_scan", ID_EXP, d);
        $display("test identity done");
        ld(INS_BYPASS);
        u_jtag_tester.scan(1'b0, 8, 32'h96, d);
        check("bypass", 32'h2C, d);
        ld(INS_RST_ASSERT);
        check("reset_on", 1, crst);
        ld(INS_RST_NEGATE);
        check("reset_off", 0, crst);
        check("ir_capture", 1, d);
        ld(INS_DBG_IRQ);
        check("irq", 5'h1F, {lvl, irq});
        ack = 1'b1;
        @(negedge clk_in);
        ack = 1'b0;
        repeat (2) @(negedge clk_in);
        check("irq_ack", 0, irq);
        $display("test commands done");
        res_n = 1'b0;
        ld(INS_SAMPLE);
        u_jtag_tester.scan(1'b0, 24, 32'h005AF0, d);
        check("sample", 32'h003CA500, d);
        ld(INS_EXTEST);
        check("extest_pads", 16'h5A0F, {pad_q, pad_oe_q});
        ld(INS_HIGHZ);
        check("highz_oe", 0, pad_oe_q);
        stby = 1'b1;
        ld(INS_BYPASS);
        check("standby", INS_HIGHZ, instr);
        stby = 1'b0;
        ld(INS_BYPASS);
        res_n = 1'b1;
        check("bypass_pads", 16'hA5FF, {pad_q, pad_oe_q});
        $display("test boundary done");
        {emu_n, res_n, trst_n} = 3'b000;
        repeat (4) @(negedge clk_in);
        check("trst_instr", INS_IDCODE, instr);
        check("port_reset", 1, prst);
        {res_n, trst_n} = 2'b11;
        repeat (4) @(negedge clk_in);
        check("hold_on", 1, hold);
        check("chip_free", 0, crst);
        res_n = 1'b0;
        repeat (4) @(negedge clk_in);
        check("hold_off", 0, hold);
        $display("test trst done");
        wrap_up();
    end
endmodule
